/* gate_driver_host_message_responder.sv */
`timescale 1ns/10ps

module gate_driver_host_message_responder
  import host_msg_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  output logic            rx_ready,
  output logic            tx_valid,
  output logic [7:0]      tx_byte,
  input  wire logic       tx_ready,
  input  wire logic [7:0] supply_fault_in,
  input  wire logic       ext_undervoltage_lockout_fault_in,
  input  wire logic       ext_oc_fault_in,
  input  wire logic       ldo_undervoltage_lockout_fault_in,
  input  wire logic       standby_in,
  output logic            pullup_disconnect_en,
  output logic            sleep_select,
  output logic            neutral_sim_en,
  output logic            ext_undervoltage_lockout_disable,
  output logic            ext_oc_det_disable,
  output logic [1:0]      ext_oc_limit_sel,
  output logic [7:0]      dac_ref,
  output logic [2:0]      dead_time_sel,
  output logic [1:0]      blanking_sel
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    fsm_type          fsm;
    logic [7:0]       cmd;
    logic [7:0]       cfg0;
    logic [7:0]       cfg1;
    logic [7:0]       cfg2;
    logic [7:0]       byte1;
    logic [7:0]       byte2;
    logic [MON_W-1:0] mon_m;
    logic [MON_W-1:0] mon_s;
    logic [MON_W-1:0] mon_p;
    logic             pend0;
    logic             pend1;
    logic             bor;
  } state_type;

  localparam state_type ST_RESET = '{
    fsm:   ST_IDLE,
    cmd:   8'h00,
    cfg0:  CFG0_RESET,
    cfg1:  CFG1_RESET,
    cfg2:  CFG2_RESET,
    byte1: 8'h00,
    byte2: 8'h00,
    mon_m: '0,
    mon_s: '0,
    mon_p: '0,
    pend0: 1'b0,
    pend1: 1'b0,
    bor:   1'b1
  };

  state_type        st_q;
  state_type        st_d;
  logic [7:0]       status0;
  logic [7:0]       status1;
  logic [MON_W-1:0] rise;
  logic             accept;
  logic [7:0]       newval;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d   = st_q;
    accept = 1'b0;
    newval = 8'h00;
    // Monitor pins are asynchronous to the link logic
    st_d.mon_m = {standby_in, ldo_undervoltage_lockout_fault_in, ext_oc_fault_in, ext_undervoltage_lockout_fault_in, supply_fault_in};
    st_d.mon_s = st_q.mon_m;
    st_d.mon_p = st_q.mon_s;
    rise       = st_q.mon_s & ~st_q.mon_p;
    status0    = st_q.mon_s[7:0];
    status1    = 8'h00;
    status1[ST1_EXT_UNDERVOLTAGE_LOCKOUT] = st_q.mon_s[MON_EXT_UNDERVOLTAGE_LOCKOUT];
    status1[ST1_EXT_OC]   = st_q.mon_s[MON_EXT_OC];
    status1[ST1_BOR]      = st_q.bor;
    status1[ST1_LDO_UNDERVOLTAGE_LOCKOUT] = st_q.mon_s[MON_LDO_UNDERVOLTAGE_LOCKOUT];

    case (st_q.fsm)
      ST_IDLE: begin
        if (rx_valid) begin
          st_d.cmd   = rx_byte;
          st_d.byte1 = (rx_byte & RESP_CODE_MASK) | RESP_ACK;
          case (rx_byte)
            CMD_SET_CFG0, CMD_SET_CFG1, CMD_SET_CFG2: begin
              st_d.fsm = ST_ARG;
            end
            CMD_GET_CFG0: begin
              st_d.byte2 = st_q.cfg0;
              st_d.fsm   = ST_SEND1;
            end
            CMD_GET_CFG1: begin
              st_d.byte2 = st_q.cfg1;
              st_d.fsm   = ST_SEND1;
            end
            CMD_GET_CFG2: begin
              st_d.byte2 = st_q.cfg2;
              st_d.fsm   = ST_SEND1;
            end
            CMD_STATUS0: begin
              st_d.byte2 = status0;
              st_d.fsm   = ST_SEND1;
            end
            CMD_STATUS1: begin
              st_d.byte2 = status1;
              st_d.bor   = 1'b0;
              st_d.fsm   = ST_SEND1;
            end
            default: begin
              // Unknown codes get no answer so the host can resync
              st_d.fsm = ST_IDLE;
            end
          endcase
        end else if (st_q.pend0) begin
          st_d.byte1 = CMD_STATUS0;
          st_d.byte2 = status0;
          st_d.pend0 = 1'b0;
          st_d.fsm   = ST_SEND1;
        end else if (st_q.pend1) begin
          st_d.byte1 = CMD_STATUS1;
          st_d.byte2 = status1;
          st_d.bor   = 1'b0;
          st_d.pend1 = 1'b0;
          st_d.fsm   = ST_SEND1;
        end
      end
      ST_ARG: begin
        if (rx_valid) begin
          case (st_q.cmd)
            CMD_SET_CFG0: begin
              accept = (rx_byte & CFG0_RSVD_MASK) == 8'h00;
              newval = rx_byte;
              if (!st_q.mon_s[MON_STANDBY]) begin
                newval[CFG0_PU_KEEP] = st_q.cfg0[CFG0_PU_KEEP];
              end
              if (accept) begin
                st_d.cfg0 = newval;
              end
              st_d.byte2 = accept ? newval : st_q.cfg0;
            end
            CMD_SET_CFG1: begin
              accept     = 1'b1;
              st_d.cfg1  = rx_byte;
              st_d.byte2 = rx_byte;
            end
            default: begin
              accept = (rx_byte & CFG2_RSVD_MASK) == 8'h00;
              if (accept) begin
                st_d.cfg2 = rx_byte;
              end
              st_d.byte2 = accept ? rx_byte : st_q.cfg2;
            end
          endcase
          st_d.byte1 = (st_q.cmd & RESP_CODE_MASK) | (accept ? RESP_ACK : 8'h00);
          st_d.fsm   = ST_SEND1;
        end
      end
      ST_SEND1: begin
        if (tx_ready) begin
          st_d.byte1 = st_q.byte2;
          st_d.fsm   = ST_SEND2;
        end
      end
      ST_SEND2: begin
        if (tx_ready) begin
          st_d.fsm = ST_IDLE;
        end
      end
      default: begin
        st_d.fsm = ST_IDLE;
      end
    endcase

    // New faults win over the clear done by sending
    if (|rise[7:0]) begin
      st_d.pend0 = 1'b1;
    end
    if (rise[MON_EXT_UNDERVOLTAGE_LOCKOUT] | rise[MON_EXT_OC] | rise[MON_LDO_UNDERVOLTAGE_LOCKOUT]) begin
      st_d.pend1 = 1'b1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rx_ready             = (st_q.fsm == ST_IDLE) || (st_q.fsm == ST_ARG);
  assign tx_valid             = (st_q.fsm == ST_SEND1) || (st_q.fsm == ST_SEND2);
  assign tx_byte              = st_q.byte1;
  // Sleep overrides the keep bit, so it never needs clearing before sleep
  assign pullup_disconnect_en = ~st_q.cfg0[CFG0_PU_KEEP] | st_q.cfg0[CFG0_SLEEP];
  assign sleep_select         = st_q.cfg0[CFG0_SLEEP];
  assign neutral_sim_en       = st_q.cfg0[CFG0_NEUSIM];
  assign ext_undervoltage_lockout_disable     = st_q.cfg0[CFG0_EXT_UNDERVOLTAGE_LOCKOUT];
  assign ext_oc_det_disable   = st_q.cfg0[CFG0_EXT_OCDET];
  assign ext_oc_limit_sel     = st_q.cfg0[CFG0_OC_HI:CFG0_OC_LO];
  assign dac_ref              = st_q.cfg1;
  assign dead_time_sel        = st_q.cfg2[CFG2_DT_HI:CFG2_DT_LO];
  assign blanking_sel         = st_q.cfg2[CFG2_BL_HI:CFG2_BL_LO];

endmodule

/* host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Host side of the message link
// ----------------------------------------
module host_model (
  input  wire logic       clk_sys,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            tx_ready
);
  logic [7:0] got[$];
  bit         slow = 0;
  initial begin
    rx_valid = 0;
    rx_byte = 8'h00;
    tx_ready = 1;
  end
  // Random stalls so that held replies get exercised
  always @(negedge clk_sys) tx_ready <= !slow || 1'($urandom_range(1));
  always @(posedge clk_sys) if (tx_valid && tx_ready) got.push_back(tx_byte);
  // Byte held until taken; released line shows the inverse, never a stale value
  task automatic send(input logic [7:0] b);
    @(negedge clk_sys);
    rx_valid = 1;
    rx_byte = b;
    do @(posedge clk_sys); while (!rx_ready);
    @(negedge clk_sys);
    rx_valid = 0;
    rx_byte = ~b;
  endtask
endmodule

/* host_msg_pkg.sv */
package host_msg_pkg;

  // ----------------------------------------
  // Command codes from host
  // ----------------------------------------
  localparam logic [7:0] CMD_SET_CFG0   = 8'h81;
  localparam logic [7:0] CMD_GET_CFG0   = 8'h82;
  localparam logic [7:0] CMD_SET_CFG1   = 8'h83;
  localparam logic [7:0] CMD_GET_CFG1   = 8'h84;
  localparam logic [7:0] CMD_STATUS0    = 8'h85;
  localparam logic [7:0] CMD_STATUS1    = 8'h86;
  localparam logic [7:0] CMD_SET_CFG2   = 8'h87;
  localparam logic [7:0] CMD_GET_CFG2   = 8'h88;

  // ----------------------------------------
  // Response encoding
  // ----------------------------------------
  localparam logic [7:0] RESP_CODE_MASK = 8'h7F;
  localparam logic [7:0] RESP_ACK       = 8'h40;

  // ----------------------------------------
  // Register layout and reset values
  // ----------------------------------------
  localparam logic [7:0] CFG0_RESET     = 8'h00;
  localparam logic [7:0] CFG1_RESET     = 8'h40;
  localparam logic [7:0] CFG2_RESET     = 8'h00;
  localparam logic [7:0] CFG0_RSVD_MASK = 8'h80;
  localparam logic [7:0] CFG2_RSVD_MASK = 8'hE0;
  localparam int         CFG0_PU_KEEP   = 6;
  localparam int         CFG0_SLEEP     = 5;
  localparam int         CFG0_NEUSIM    = 4;
  localparam int         CFG0_EXT_UNDERVOLTAGE_LOCKOUT  = 3;
  localparam int         CFG0_EXT_OCDET = 2;
  localparam int         CFG0_OC_HI     = 1;
  localparam int         CFG0_OC_LO     = 0;
  localparam int         CFG2_DT_HI     = 4;
  localparam int         CFG2_DT_LO     = 2;
  localparam int         CFG2_BL_HI     = 1;
  localparam int         CFG2_BL_LO     = 0;
  localparam int         ST1_EXT_UNDERVOLTAGE_LOCKOUT   = 2;
  localparam int         ST1_EXT_OC     = 3;
  localparam int         ST1_BOR        = 4;
  localparam int         ST1_LDO_UNDERVOLTAGE_LOCKOUT   = 5;

  // ----------------------------------------
  // Monitor vector layout
  // ----------------------------------------
  localparam int         MON_W          = 12;
  localparam int         MON_EXT_UNDERVOLTAGE_LOCKOUT   = 8;
  localparam int         MON_EXT_OC     = 9;
  localparam int         MON_LDO_UNDERVOLTAGE_LOCKOUT   = 10;
  localparam int         MON_STANDBY    = 11;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARG   = 2'b01,
    ST_SEND1 = 2'b11,
    ST_SEND2 = 2'b10
  } fsm_type;

endpackage

/* responder_checker_sva.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Link reply checks
// ----------------------------------------
module responder_checker
  import host_msg_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic       rx_ready,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_ready,
  input wire logic       pullup_disconnect_en,
  input wire logic       sleep_select,
  input wire logic [7:0] dac_ref
);
  // Tracks whether the next taken byte is an argument, not a command
  logic       arg_q;
  logic       arg_d;
  // Command whose argument is awaited; the host may leave idle cycles before the argument
  logic [7:0] last_q;
  wire  take = rx_valid && rx_ready;
  wire  cmd  = take && !arg_q;
  always_comb arg_d = take ? (cmd && rx_byte inside {CMD_SET_CFG0, CMD_SET_CFG1, CMD_SET_CFG2}) : arg_q;
  always_ff @(posedge clk_sys or posedge rst) arg_q <= rst ? 1'b0 : arg_d;
  always_ff @(posedge clk_sys or posedge rst) last_q <= rst ? 8'h00 : (cmd ? rx_byte : last_q);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_ask(logic [7:0] c); cmd && rx_byte == c; endsequence
  sequence s_set(logic [7:0] c); take && arg_q && last_q == c; endsequence
  property p_get0; s_ask(CMD_GET_CFG0) |=> tx_valid && tx_byte == 8'h42; endproperty
  property p_get1; s_ask(CMD_GET_CFG1) |=> tx_valid && tx_byte == 8'h44; endproperty
  property p_st0; s_ask(CMD_STATUS0) |=> tx_valid && tx_byte == 8'h45; endproperty
  property p_st1; s_ask(CMD_STATUS1) |=> tx_valid && tx_byte == 8'h46; endproperty
  property p_nack0; s_set(CMD_SET_CFG0) ##0 rx_byte[7] |=> tx_valid && tx_byte == 8'h01; endproperty
  property p_ack0; s_set(CMD_SET_CFG0) ##0 !rx_byte[7] |=> tx_valid && tx_byte == 8'h41; endproperty
  property p_set1; s_set(CMD_SET_CFG1) |=> tx_byte == 8'h43 && dac_ref == $past(rx_byte); endproperty
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte) && !rx_ready; endproperty
  property p_code; $rose(tx_valid) |-> !(tx_byte[7] && tx_byte[6]) && tx_byte[5:0] inside {[1:8]}; endproperty
  property p_sleep; sleep_select |-> pullup_disconnect_en; endproperty
  a_get0: assert property (p_get0) else $error("get cfg0 reply code wrong");
  a_get1: assert property (p_get1) else $error("get reference reply code wrong");
  a_st0: assert property (p_st0) else $error("status0 reply code wrong");
  a_st1: assert property (p_st1) else $error("status1 reply code wrong");
  a_nack0: assert property (p_nack0) else $error("reserved cfg0 write not refused");
  a_ack0: assert property (p_ack0) else $error("cfg0 write not accepted");
  a_set1: assert property (p_set1) else $error("reference write reply or value wrong");
  a_hold: assert property (p_hold) else $error("reply byte dropped before taken");
  a_code: assert property (p_code) else $error("reply first byte malformed");
  a_sleep: assert property (p_sleep) else $error("sleep without pull-up disconnect");
endmodule
bind gate_driver_host_message_responder responder_checker responder_checker_inst (.clk_sys, .rst, .rx_valid,
  .rx_byte, .rx_ready, .tx_valid, .tx_byte, .tx_ready, .pullup_disconnect_en, .sleep_select, .dac_ref);

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
  import host_msg_pkg::*;
  logic       clk_sys, rst, rx_valid, rx_ready, tx_valid, tx_ready, standby_in;
  logic       ext_undervoltage_lockout_fault_in, ext_oc_fault_in, ldo_undervoltage_lockout_fault_in, pullup_disconnect_en;
  logic       sleep_select, neutral_sim_en, ext_undervoltage_lockout_disable, ext_oc_det_disable;
  logic [1:0] ext_oc_limit_sel, blanking_sel;
  logic [2:0] dead_time_sel;
  logic [7:0] rx_byte, tx_byte, supply_fault_in, dac_ref, c0, v;
  int         fail_count, check_count;
  gate_driver_host_message_responder gate_driver_host_message_responder_inst (.clk_sys, .rst, .rx_valid,
    .rx_byte, .rx_ready, .tx_valid, .tx_byte, .tx_ready, .supply_fault_in, .ext_undervoltage_lockout_fault_in, .ext_oc_fault_in,
    .ldo_undervoltage_lockout_fault_in, .standby_in, .pullup_disconnect_en, .sleep_select, .neutral_sim_en, .ext_undervoltage_lockout_disable,
    .ext_oc_det_disable, .ext_oc_limit_sel, .dac_ref, .dead_time_sel, .blanking_sel);
  host_model host_model_inst (.clk_sys, .rx_ready, .tx_valid, .tx_byte, .rx_valid, .rx_byte, .tx_ready);
  // ----------------------------------------
  // Expectation and check helpers
  // ----------------------------------------
  function automatic logic [7:0] nx0(input logic [7:0] o, b, input logic sb);
    if (b[7]) return o;
    return {1'b0, sb ? b[6] : o[6], b[5:0]};
  endfunction
  task automatic chk(input logic [7:0] a, e);
    check_count++;
    if (a !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  // Bounded wait: a silent design leaves the queue short and the compare fails
  task automatic wait2(input logic [7:0] e1, e2);
    for (int n = 0; n < 200 && host_model_inst.got.size() < 2; n++) @(posedge clk_sys);
    chk(host_model_inst.got[0], e1);
    chk(host_model_inst.got[1], e2);
    host_model_inst.got.delete();
  endtask
  task automatic xact(input logic [7:0] c, input logic [8:0] a, input logic [7:0] e1, e2);
    host_model_inst.send(c);
    if (a[8]) host_model_inst.send(a[7:0]);
    wait2(e1, e2);
  endtask
  task automatic unsol(input logic [7:0] s, input logic [2:0] x, input logic [7:0] e1, e2);
    @(negedge clk_sys);
    supply_fault_in = s;
    {ext_undervoltage_lockout_fault_in, ext_oc_fault_in, ldo_undervoltage_lockout_fault_in} = x;
    wait2(e1, e2);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #(100 * 20000);
    fail_count++;
    finish_test();
  end
  initial begin
    v = 8'($urandom(32'hE25A2F1E));
    {rst, standby_in, ext_undervoltage_lockout_fault_in, ext_oc_fault_in, ldo_undervoltage_lockout_fault_in, supply_fault_in} = 13'h1800;
    repeat (12) @(negedge clk_sys);
    rst = 0;
    c0 = 8'h00;
    xact(CMD_GET_CFG0, 9'h000, 8'h42, 8'h00);
    xact(CMD_GET_CFG1, 9'h000, 8'h44, 8'h40);
    xact(CMD_GET_CFG2, 9'h000, 8'h48, 8'h00);
    xact(CMD_STATUS1, 9'h000, 8'h46, 8'h10);
    xact(CMD_STATUS1, 9'h000, 8'h46, 8'h00);
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 8'h80 : 8'($urandom);
      if (i == 8) begin
        @(negedge clk_sys);
        standby_in = 0;
        repeat (4) @(negedge clk_sys);
      end
      if (i >= 8) v[6] = ~c0[6];
      host_model_inst.slow = i[0];
      c0 = nx0(c0, v, standby_in);
      xact(CMD_SET_CFG0, {1'b1, v}, v[7] ? 8'h01 : 8'h41, c0);
      chk({pullup_disconnect_en, sleep_select, neutral_sim_en, ext_undervoltage_lockout_disable, ext_oc_det_disable,
        ext_oc_limit_sel, 1'b0}, {~c0[6] | c0[5], c0[5:0], 1'b0});
      xact(CMD_GET_CFG0, 9'h000, 8'h42, c0);
      v = (i == 1) ? 8'hFF : (i == 2) ? 8'h00 : 8'($urandom);
      xact(CMD_SET_CFG1, {1'b1, v}, 8'h43, v);
      chk(dac_ref, v);
    end
    xact(CMD_SET_CFG2, 9'h1E0, 8'h07, 8'h00);
    xact(CMD_SET_CFG2, 9'h11D, 8'h47, 8'h1D);
    chk({3'b000, dead_time_sel, blanking_sel}, 8'h1D);
    v = 8'($urandom_range(255, 1));
    unsol(v, 3'b000, 8'h85, v);
    xact(CMD_STATUS0, 9'h000, 8'h45, v);
    unsol(8'h00, 3'b111, 8'h86, 8'h2C);
    xact(CMD_STATUS1, 9'h000, 8'h46, 8'h2C);
    finish_test();
  end
endmodule
